// ---- cpl_device.sv ----
// palette device: lookup memory, pixel pipeline, host strobe port
`timescale 1ns/1ns
module cpl_device
	import cpl_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	cpl_link_if.device link,
	output logic [5:0] red,
	output logic [5:0] green,
	output logic [5:0] blue
);
	// pixel clock is mclk; the pixel pins are sampled directly
	logic [7:0] pix_q;
	logic blank_q;
	logic [7:0] lut_addr_q;
	logic blank_q2;
	logic [CPL_WORD_W-1:0] lut_q;
	logic blank_q3;
	logic [CPL_WORD_W-1:0] palette [CPL_ENTRIES];
	// host side: async strobes pass four flops, selects and data two flops each
	logic [1:0] rd_sync;
	logic [1:0] wr_sync;
	logic [1:0] rd_s;
	logic [1:0] wr_s;
	logic [7:0] data_s1;
	logic [7:0] data_s2;
	logic [1:0] sel_s1;
	logic [1:0] sel_s2;
	logic rd_prev;
	logic wr_prev;
	logic [1:0] sel_lat;
	logic [7:0] pix_mask;
	logic [7:0] host_addr;
	logic [CPL_WORD_W-1:0] value;
	logic [1:0] phase;
	logic fetch_pending;
	logic [7:0] rd_byte;
	logic rd_active;
	// write requests travel through the fifo to the palette port
	logic wq_valid;
	logic wq_ready;
	logic [25:0] wq_in;
	logic [25:0] wq_out;
	logic wq_in_valid;
	logic wq_in_ready;
	wire rd_low = ~rd_s[1];
	wire wr_low = ~wr_s[1];
	wire rd_fall = rd_prev && rd_low;
	wire wr_fall = wr_prev && wr_low;
	wire rd_rise = !rd_prev && !rd_low;
	wire wr_rise = !wr_prev && !wr_low;
	wire [CPL_WORD_W-1:0] next_value_wr = (phase == CPL_PHASE_RED) ?
		{data_s2[5:0], value[11:0]} : (phase == CPL_PHASE_GREEN) ?
		{value[17:12], data_s2[5:0], value[5:0]} :
		{value[17:6], data_s2[5:0]};
	wire blue_done = wr_rise && sel_lat == CPL_SEL_VALUE &&
		phase == CPL_PHASE_BLUE;
	wire [5:0] rd_chan = (phase == CPL_PHASE_RED) ? value[17:12] :
		(phase == CPL_PHASE_GREEN) ? value[11:6] : value[5:0];
	wire [7:0] next_rd_byte = (sel_lat == CPL_SEL_MASK) ? pix_mask :
		(sel_lat == CPL_SEL_VALUE) ? {2'h0, rd_chan} : host_addr;
	wire do_fetch = fetch_pending && !wq_valid;
	assign wq_in = {host_addr, next_value_wr};
	assign wq_in_valid = blue_done;
	assign wq_ready = 1'b1;

	cpl_fifo #(.WIDTH(26), .DEPTH(CPL_FIFO_DEPTH)) u_wq (
		.mclk(mclk),
		.reset(reset),
		.in_valid(wq_in_valid),
		.in_ready(wq_in_ready),
		.in_data(wq_in),
		.out_valid(wq_valid),
		.out_ready(wq_ready),
		.out_data(wq_out)
	);

	// pixel pipeline: sample, mask, lookup, output latch
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pix_q <= '0;
			blank_q <= 1'b0;
			lut_addr_q <= '0;
			blank_q2 <= 1'b0;
			lut_q <= '0;
			blank_q3 <= 1'b0;
			red <= '0;
			green <= '0;
			blue <= '0;
		end else begin
			pix_q <= link.pixel_index;
			blank_q <= link.blank_n;
			lut_addr_q <= pix_q & pix_mask;
			blank_q2 <= blank_q;
			lut_q <= palette[lut_addr_q];
			blank_q3 <= blank_q2;
			red <= blank_q3 ? lut_q[17:12] : '0;
			green <= blank_q3 ? lut_q[11:6] : '0;
			blue <= blank_q3 ? lut_q[5:0] : '0;
		end
	end

	// palette write port ignores blanking; host address only
	always_ff @(posedge mclk) begin
		if (wq_valid)
			palette[wq_out[25:18]] <= wq_out[17:0];
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_sync <= 2'h3;
			wr_sync <= 2'h3;
			rd_s <= 2'h3;
			wr_s <= 2'h3;
			data_s1 <= '0;
			data_s2 <= '0;
			sel_s1 <= '0;
			sel_s2 <= '0;
			rd_prev <= 1'b1;
			wr_prev <= 1'b1;
		end else begin
			// strobes pass two more flops than data and selects, so those
			// have settled by the time a strobe edge is seen
			rd_sync <= {rd_sync[0], link.rd_n};
			wr_sync <= {wr_sync[0], link.wr_n};
			rd_s <= {rd_s[0], rd_sync[1]};
			wr_s <= {wr_s[0], wr_sync[1]};
			data_s1 <= link.host_data;
			data_s2 <= data_s1;
			sel_s1 <= link.register_select;
			sel_s2 <= sel_s1;
			rd_prev <= !rd_low;
			wr_prev <= !wr_low;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sel_lat <= CPL_SEL_ADDR_WR;
			pix_mask <= CPL_MASK_RESET;
			host_addr <= CPL_ADDR_RESET;
			value <= '0;
			phase <= CPL_PHASE_RED;
			fetch_pending <= 1'b0;
		end else begin
			if (rd_fall || wr_fall)
				sel_lat <= sel_s2;
			if (do_fetch) begin
				value <= palette[host_addr];
				host_addr <= host_addr + 8'h01;
				fetch_pending <= 1'b0;
			end
			if (wr_rise) begin
				case (sel_lat)
				CPL_SEL_ADDR_WR: begin
					host_addr <= data_s2;
					phase <= CPL_PHASE_RED;
				end
				CPL_SEL_ADDR_RD: begin
					host_addr <= data_s2;
					phase <= CPL_PHASE_RED;
					fetch_pending <= 1'b1;
				end
				CPL_SEL_MASK: pix_mask <= data_s2;
				CPL_SEL_VALUE: begin
					value <= next_value_wr;
					if (phase == CPL_PHASE_BLUE) begin
						phase <= CPL_PHASE_RED;
						host_addr <= host_addr + 8'h01;
					end else
						phase <= phase + 2'h1;
				end
				default: phase <= CPL_PHASE_RED;
				endcase
			end else if (rd_rise && sel_lat == CPL_SEL_VALUE) begin
				if (phase == CPL_PHASE_BLUE) begin
					phase <= CPL_PHASE_RED;
					fetch_pending <= 1'b1;
				end else
					phase <= phase + 2'h1;
			end
		end
	end

	// data pins: driven from the second cycle after the synchronised read strobe's fall is seen until one cycle after it is seen high again
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_byte <= '0;
			rd_active <= 1'b0;
		end else begin
			rd_active <= rd_low && !rd_fall;
			rd_byte <= next_rd_byte;
		end
	end
	assign link.host_data_out_dev = rd_byte;
	assign link.host_data_oe_dev = rd_active;
endmodule

// ---- cpl_pkg.sv ----
// shared constants and types for the colour palette lookup port
package cpl_pkg;
	localparam int CPL_ENTRIES = 256;
	localparam int CPL_IDX_W = 8;
	localparam int CPL_CHAN_W = 6;
	localparam int CPL_WORD_W = 18;
	localparam int CPL_PIPE_STAGES = 3;
	localparam int CPL_FIFO_DEPTH = 8;
	localparam logic [7:0] CPL_MASK_RESET = 8'hFF;
	localparam logic [7:0] CPL_ADDR_RESET = 8'h00;
	localparam logic [1:0] CPL_PHASE_RED = 2'h0;
	localparam logic [1:0] CPL_PHASE_GREEN = 2'h1;
	localparam logic [1:0] CPL_PHASE_BLUE = 2'h2;
	// strobe timing on the host side, in mclk cycles
	localparam int CPL_SETUP_CYCLES = 2;
	// the device sees a strobe four flops late and drives two later still;
	// the strobe must last until that byte has crossed back to the host
	localparam int CPL_STROBE_CYCLES = 8;
	// the device lets go of the data pins only once it sees the strobe rise
	localparam int CPL_HOLD_CYCLES = 4;
	// register select codes {sel1, sel0}
	typedef enum logic [1:0] {
		CPL_SEL_ADDR_WR = 2'h0,
		CPL_SEL_VALUE = 2'h1,
		CPL_SEL_MASK = 2'h2,
		CPL_SEL_ADDR_RD = 2'h3
	} cpl_sel_t;
endpackage

// ---- cpl_link_if.sv ----
// pins between the palette device and its host and graphics controller
`timescale 1ns/1ns
interface cpl_link_if;
	logic [7:0] pixel_index;
	logic blank_n;
	logic [1:0] register_select;
	logic rd_n;
	logic wr_n;
	logic [7:0] host_data_out_host;
	logic host_data_oe_host;
	logic [7:0] host_data_out_dev;
	logic host_data_oe_dev;
	wire [7:0] host_data;
	assign host_data = host_data_oe_dev ? host_data_out_dev :
		host_data_oe_host ? host_data_out_host : 8'hFF;
	modport device (input pixel_index, blank_n, register_select, rd_n,
		wr_n, host_data, output host_data_out_dev, host_data_oe_dev);
	modport host (output pixel_index, blank_n, register_select, rd_n,
		wr_n, host_data_out_host, host_data_oe_host, input host_data);
endinterface

// ---- cpl_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module cpl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW:0] used = wr_ptr - rd_ptr;
	assign in_ready = used != (AW+1)'(DEPTH);
	assign out_valid = used != '0;
	assign out_data = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge mclk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// ---- cpl_host.sv ----
// host and graphics controller end: strobe sequencer and pixel driver
`timescale 1ns/1ns
module cpl_host
	import cpl_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	cpl_link_if.host link,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_sel,
	input wire logic [7:0] req_data,
	output logic req_ready,
	output logic resp_valid,
	output logic [7:0] resp_data,
	input wire logic [7:0] pix_in,
	input wire logic blank_n_in
);
	typedef enum {CPL_IDLE, CPL_SETUP, CPL_STROBE, CPL_HOLD} cpl_state_t;
	cpl_state_t state;
	logic [3:0] cnt;
	logic is_write;
	logic [7:0] rd_sync1;
	logic [7:0] rd_sync2;
	wire cnt_done = cnt == 4'h0;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			link.pixel_index <= '0;
			link.blank_n <= 1'b0;
		end else begin
			link.pixel_index <= pix_in;
			link.blank_n <= blank_n_in;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_sync1 <= '0;
			rd_sync2 <= '0;
		end else begin
			rd_sync1 <= link.host_data;
			rd_sync2 <= rd_sync1;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= CPL_IDLE;
			cnt <= '0;
			is_write <= 1'b0;
			req_ready <= 1'b1;
			resp_valid <= 1'b0;
			resp_data <= '0;
			link.register_select <= '0;
			link.rd_n <= 1'b1;
			link.wr_n <= 1'b1;
			link.host_data_out_host <= '0;
			link.host_data_oe_host <= 1'b0;
		end else begin
			resp_valid <= 1'b0;
			if (!cnt_done)
				cnt <= cnt - 4'h1;
			case (state)
			CPL_IDLE: if (req_valid) begin
				req_ready <= 1'b0;
				is_write <= req_write;
				link.register_select <= req_sel;
				link.host_data_out_host <= req_data;
				link.host_data_oe_host <= req_write;
				cnt <= 4'(CPL_SETUP_CYCLES);
				state <= CPL_SETUP;
			end
			CPL_SETUP: if (cnt_done) begin
				link.rd_n <= is_write;
				link.wr_n <= !is_write;
				cnt <= 4'(CPL_STROBE_CYCLES);
				state <= CPL_STROBE;
			end
			CPL_STROBE: if (cnt_done) begin
				// data held through the rising edge
				link.rd_n <= 1'b1;
				link.wr_n <= 1'b1;
				if (!is_write) begin
					resp_valid <= 1'b1;
					resp_data <= rd_sync2;
				end
				cnt <= 4'(CPL_HOLD_CYCLES);
				state <= CPL_HOLD;
			end
			CPL_HOLD: if (cnt_done) begin
				link.host_data_oe_host <= 1'b0;
				req_ready <= 1'b1;
				state <= CPL_IDLE;
			end
			default: state <= CPL_IDLE;
			endcase
		end
	end
endmodule

// ---- cpl_link_chk.sv ----
// protocol checker for the palette host strobe port
`timescale 1ns/1ns
module cpl_link_chk (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [1:0] register_select,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] host_data_out_host,
	input wire logic host_data_oe_host,
	input wire logic host_data_oe_dev,
	input wire logic blank_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_single_driver: assert property (
		!(host_data_oe_dev && host_data_oe_host))
		else $error("both ends drive host data");
	a_dev_drives_read: assert property (
		$fell(rd_n) |-> ##6 host_data_oe_dev)
		else $error("device never drove during read");
	a_dev_oe_cause: assert property (
		$rose(host_data_oe_dev) |-> !rd_n)
		else $error("device drove without read strobe");
	a_dev_release: assert property (
		$rose(rd_n) |-> ##[1:6] !host_data_oe_dev)
		else $error("device kept driving after read");
	a_strobe_excl: assert property (
		!(!rd_n && !wr_n))
		else $error("read and write strobes both low");
	a_sel_hold: assert property (
		(!rd_n || !wr_n) |-> $stable(register_select))
		else $error("select moved inside a strobe");
	a_wr_data_hold: assert property (
		!wr_n |-> host_data_oe_host && $stable(host_data_out_host))
		else $error("write data not held under strobe");
	a_wr_width: assert property (
		$fell(wr_n) |-> !wr_n [*4])
		else $error("write strobe too short");
	a_rd_width: assert property (
		$fell(rd_n) |-> !rd_n [*4])
		else $error("read strobe too short");
	a_host_quiet_read: assert property (
		!rd_n |-> !host_data_oe_host)
		else $error("host drove during read");
	c_read: cover property ($fell(rd_n));
	c_write: cover property ($fell(wr_n));
	c_blank: cover property ($fell(blank_n));
endmodule

// ---- testbench.sv ----
// end to end bench: host end driving the palette device
`timescale 1ns/1ns
module testbench
	import cpl_pkg::*;
;
	logic mclk, reset, req_valid, req_write, req_ready, resp_valid;
	logic [1:0] req_sel;
	logic [7:0] req_data, resp_data, pix_in, q;
	logic blank_n_in;
	logic [5:0] red, green, blue;
	int mismatches, n_checks;
	cpl_link_if link ();
	cpl_device u_cpl_device (.mclk(mclk), .reset(reset), .link(link),
		.red(red), .green(green), .blue(blue));
	cpl_host u_cpl_host (.mclk(mclk), .reset(reset), .link(link),
		.req_valid(req_valid), .req_write(req_write), .req_sel(req_sel),
		.req_data(req_data), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp_data(resp_data),
		.pix_in(pix_in), .blank_n_in(blank_n_in));
	cpl_link_chk u_cpl_link_chk (.mclk(mclk), .reset(reset),
		.register_select(link.register_select), .rd_n(link.rd_n),
		.wr_n(link.wr_n), .host_data_out_host(link.host_data_out_host),
		.host_data_oe_host(link.host_data_oe_host),
		.host_data_oe_dev(link.host_data_oe_dev), .blank_n(link.blank_n));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic give_up();
		mismatches++;
		$display("unexpected at %0t: wait ran out", $time);
		summarize();
	endtask
	// one strobe cycle; the host end holds select and write data until it is idle
	task automatic xfer(input logic wr, input logic [1:0] sel,
		input logic [7:0] d);
		int i;
		@(negedge mclk);
		for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge mclk);
		if (i >= 100) give_up();
		req_valid = 1'b1;
		req_write = wr;
		req_sel = sel;
		req_data = d;
		@(negedge mclk);
		req_valid = 1'b0;
		for (i = 0; i < 100; i++) begin
			@(posedge mclk);
			#1;
			if (resp_valid === 1'b1) q = resp_data;
			if (req_ready === 1'b1) break;
		end
		if (i >= 100) give_up();
	endtask
	task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
		q = 8'hXX;
		xfer(1'b0, sel, 8'h00);
		chk(q, exp);
	endtask
	// waits k pixel clocks, then compares all three colour codes
	task automatic pix(input int k, input logic [17:0] e);
		repeat (k) @(negedge mclk);
		chk({2'h0, red}, {2'h0, e[17:12]});
		chk({2'h0, green}, {2'h0, e[11:6]});
		chk({2'h0, blue}, {2'h0, e[5:0]});
	endtask
	initial begin
		{mismatches, n_checks, req_valid, req_write} = '0;
		{req_sel, req_data, pix_in} = '0;
		blank_n_in = 1'b0;
		reset = 1'b1;
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		rd(CPL_SEL_MASK, CPL_MASK_RESET);
		xfer(1'b1, CPL_SEL_MASK, 8'hFE);
		rd(CPL_SEL_MASK, 8'hFE);
		$display("test mask done");
		// palette loaded while blanked, upper data bits must be dropped
		xfer(1'b1, CPL_SEL_ADDR_WR, 8'h10);
		xfer(1'b1, CPL_SEL_VALUE, 8'hC5);
		xfer(1'b1, CPL_SEL_VALUE, 8'h3A);
		xfer(1'b1, CPL_SEL_VALUE, 8'hFF);
		xfer(1'b1, CPL_SEL_VALUE, 8'h41);
		xfer(1'b1, CPL_SEL_VALUE, 8'h02);
		xfer(1'b1, CPL_SEL_VALUE, 8'h83);
		$display("test write done");
		xfer(1'b1, CPL_SEL_ADDR_RD, 8'h10);
		rd(CPL_SEL_VALUE, 8'h05);
		rd(CPL_SEL_VALUE, 8'h3A);
		rd(CPL_SEL_VALUE, 8'h3F);
		rd(CPL_SEL_VALUE, 8'h01);
		rd(CPL_SEL_VALUE, 8'h02);
		rd(CPL_SEL_VALUE, 8'h03);
		$display("test read done");
		pix(8, 18'h0);
		pix_in = 8'h11;
		blank_n_in = 1'b1;
		pix(4, 18'h0);
		pix(1, {6'h05, 6'h3A, 6'h3F});
		blank_n_in = 1'b0;
		pix(4, {6'h05, 6'h3A, 6'h3F});
		pix(1, 18'h0);
		$display("test pixel done");
		// three prefetches moved the address past both entries
		rd(CPL_SEL_ADDR_WR, 8'h13);
		// top entry: the stored word goes through the write queue
		xfer(1'b1, CPL_SEL_ADDR_WR, 8'hFF);
		xfer(1'b1, CPL_SEL_VALUE, 8'h2A);
		xfer(1'b1, CPL_SEL_VALUE, 8'h15);
		xfer(1'b1, CPL_SEL_VALUE, 8'h7C);
		rd(CPL_SEL_ADDR_WR, 8'h00);
		xfer(1'b1, CPL_SEL_ADDR_RD, 8'hFF);
		rd(CPL_SEL_VALUE, 8'h2A);
		rd(CPL_SEL_VALUE, 8'h15);
		rd(CPL_SEL_VALUE, 8'h3C);
		rd(CPL_SEL_ADDR_RD, 8'h01);
		$display("test wrap done");
		summarize();
	end
endmodule
